// ---- design/dmat_arb.sv ----
`timescale 1ns/100ps
// picks the first requesting channel, starting from the top one
module dmat_arb
    import dmat_pkg::*;
(
    input wire logic [2:0] req, // eligible channels
    input wire logic [1:0] top, // channel ranked highest
    output logic valid, // some channel wins
    output logic [1:0] idx // winning channel
);
    // ======================================================
    // cyclic scan starts at top and wraps from channel 2 back to 0
    always_comb begin
        logic [1:0] c;
        c = top;
        valid = 1'b0;
        idx = 2'h0;
        for (int k = 0; k < 3; k++) begin
            if (!valid && req[c]) begin
                valid = 1'b1;
                idx = c;
            end
            c = (c == 2'h2) ? 2'h0 : 2'(c + 2'h1);
        end
    end
endmodule

// ---- design/dmat_consts.svh ----
`ifndef DMAT_CONSTS_SVH
`define DMAT_CONSTS_SVH

// ==========================================================
// register offsets (byte addresses on the APB)
`define DMAT_GCTL_OFS 8'h00
`define DMAT_STAT_OFS 8'h04
`define DMAT_CCTL_BASE 8'h10
`define DMAT_SIZE_BASE 8'h20

// ==========================================================
// global control fields
`define DMAT_GCTL_RR 0
`define DMAT_GCTL_NMI 1

// channel control fields
`define DMAT_CCTL_SEL_LO 0
`define DMAT_CCTL_SEL_HI 3
`define DMAT_CCTL_EN 4
`define DMAT_CCTL_SWREQ 5
`define DMAT_CCTL_DONE 6
`define DMAT_CCTL_LEVEL 7
`define DMAT_CCTL_MODE_LO 8
`define DMAT_CCTL_MODE_HI 9

// status fields
`define DMAT_STAT_BUSY 0
`define DMAT_STAT_CUR_LO 1
`define DMAT_STAT_CUR_HI 2
`define DMAT_STAT_TOP_LO 3
`define DMAT_STAT_TOP_HI 4
`define DMAT_STAT_MCLK 5
`define DMAT_STAT_HALT 6

// ==========================================================
// trigger selector codes
`define DMAT_SEL_SOFT 4'h0
`define DMAT_SEL_MPY 4'hB
`define DMAT_SEL_SRX 4'hC
`define DMAT_SEL_STX 4'hD
`define DMAT_SEL_CHAIN 4'hE
`define DMAT_SEL_EXT 4'hF

// transfer modes
`define DMAT_MODE_SINGLE 2'h0
`define DMAT_MODE_BLOCK 2'h1
`define DMAT_MODE_BURST 2'h2

// ==========================================================
// reset values
`define DMAT_RST_WORD 32'h0000_0000
`define DMAT_RST_TOP 2'h0

// ==========================================================
// timing
`define DMAT_CLK_PERIOD_NS 10
`define DMAT_OSC_START_NS 6000
`define DMAT_OSC_START_CYC \
    ((`DMAT_OSC_START_NS + `DMAT_CLK_PERIOD_NS - 1) / `DMAT_CLK_PERIOD_NS)
`define DMAT_SYNC_ACTIVE 10'h000
`define DMAT_SYNC_LOWPWR 10'h001

`endif

// ---- design/dmat_core.sv ----
`timescale 1ns/100ps
`include "dmat_consts.svh"
module dmat_core
    import dmat_pkg::*;
(
    input wire logic pclk, // master clock
    input wire logic presetn, // async reset, active low
    input wire dmat_apb_req_t apb_req, // apb request
    output dmat_apb_rsp_t apb_rsp, // apb answer
    input wire dmat_trig_in_t trig_in, // peripheral triggers
    input wire logic nmi, // non-maskable interrupt
    input wire logic mclk_running, // master clock is on
    input wire logic cpu_off, // cpu in a low-power mode
    output logic mclk_request, // keep oscillator clock up
    output logic cpu_halt, // cpu held for a transfer
    output logic serial_b_rx_clear, // clear rx flag, pulse
    output logic serial_b_tx_clear, // clear tx flag, pulse
    output logic xfer_read, // read cycle of a unit
    output logic xfer_write, // write cycle of a unit
    output logic [1:0] xfer_chan, // channel moving data
    output logic [2:0] channel_done_flag // per channel done
);
    dmat_state_t s;
    dmat_state_t next_s;
    logic [2:0] trig;
    logic [2:0] elig;
    logic gnt_valid;
    logic [1:0] gnt_idx;
    logic [1:0] eff_top;

    // ======================================================
    // trigger selection per channel
    for (genvar i = 0; i < 3; i++) begin : g_trig
        localparam int PREV = (i + 2) % 3;
        always_comb begin
            case (s.ch[i].sel)
                `DMAT_SEL_SOFT: trig[i] = s.ch[i].swreq;
                `DMAT_SEL_MPY: trig[i] = trig_in.mpy_ready;
                `DMAT_SEL_SRX: trig[i] = trig_in.serial_b_fitted
                    && trig_in.serial_b_rx_flag
                    && !trig_in.serial_b_rx_irq_enable;
                `DMAT_SEL_STX: trig[i] = trig_in.serial_b_fitted
                    && trig_in.serial_b_tx_flag
                    && !trig_in.serial_b_tx_irq_enable;
                `DMAT_SEL_CHAIN: trig[i] = s.ch[PREV].done;
                `DMAT_SEL_EXT: trig[i] = trig_in.external_trigger_pin;
                default: trig[i] = 1'b0;
            endcase
        end
        // level mode follows the trigger, edge mode needs a capture
        assign elig[i] = s.ch[i].en && (s.ch[i].size != 16'h0000)
            && (s.ch[i].level ? trig[i] : s.pend[i]);
    end

    // fixed order returns at once when rotation is off
    assign eff_top = s.rr ? s.top : 2'h0;

    // the scan starts at the top channel and wraps around
    dmat_arb u_arb (
        .req(elig),
        .top(eff_top),
        .valid(gnt_valid),
        .idx(gnt_idx)
    );

    // ======================================================
    // next state: bus slave first, then engine, so hw sets win
    always_comb begin
        logic [31:0] rd;
        logic hit;
        logic [1:0] idx;
        logic fin;
        logic [1:0] c;
        rd = `DMAT_RST_WORD;
        hit = 1'b0;
        idx = 2'h0;
        fin = 1'b0;
        c = s.cur;
        next_s = s;
        next_s.rx_clr = 1'b0;
        next_s.tx_clr = 1'b0;
        next_s.xrd = 1'b0;
        next_s.xwr = 1'b0;
        next_s.rsp.pready = 1'b0;
        next_s.rsp.pslverr = 1'b0;

        // ==================================================
        // address decode
        // slot 3 of each channel bank is unmapped: error
        idx = 2'(apb_req.paddr[3:2]);
        if (apb_req.paddr == `DMAT_GCTL_OFS) begin
            hit = 1'b1;
            rd[`DMAT_GCTL_RR] = s.rr;
            rd[`DMAT_GCTL_NMI] = s.nmi_en;
        end else if (apb_req.paddr == `DMAT_STAT_OFS) begin
            hit = 1'b1;
            rd[`DMAT_STAT_BUSY] = (s.fsm != DMAT_IDLE);
            rd[`DMAT_STAT_CUR_HI:`DMAT_STAT_CUR_LO] = s.cur;
            rd[`DMAT_STAT_TOP_HI:`DMAT_STAT_TOP_LO] = eff_top;
            rd[`DMAT_STAT_MCLK] = s.mclk_req;
            rd[`DMAT_STAT_HALT] = s.cpu_halt;
        end else if ((apb_req.paddr & 8'hF0) == `DMAT_CCTL_BASE
                && idx != 2'h3) begin
            hit = 1'b1;
            rd[`DMAT_CCTL_SEL_HI:`DMAT_CCTL_SEL_LO] = s.ch[idx].sel;
            rd[`DMAT_CCTL_EN] = s.ch[idx].en;
            rd[`DMAT_CCTL_SWREQ] = s.ch[idx].swreq;
            rd[`DMAT_CCTL_DONE] = s.ch[idx].done;
            rd[`DMAT_CCTL_LEVEL] = s.ch[idx].level;
            rd[`DMAT_CCTL_MODE_HI:`DMAT_CCTL_MODE_LO] = s.ch[idx].mode;
        end else if ((apb_req.paddr & 8'hF0) == `DMAT_SIZE_BASE
                && idx != 2'h3) begin
            hit = 1'b1;
            rd[15:0] = s.ch[idx].size;
        end

        // setup phase: answer is ready for the access phase
        if (apb_req.psel && !apb_req.penable) begin
            next_s.rsp.pready = 1'b1;
            next_s.rsp.pslverr = !hit;
            next_s.rsp.prdata = apb_req.pwrite ? `DMAT_RST_WORD : rd;
        end

        // access phase: the write takes effect here
        if (apb_req.psel && apb_req.penable && s.rsp.pready
                && apb_req.pwrite && hit) begin
            if (apb_req.paddr == `DMAT_GCTL_OFS) begin
                next_s.rr = apb_req.pwdata[`DMAT_GCTL_RR];
                next_s.nmi_en = apb_req.pwdata[`DMAT_GCTL_NMI];
            end else if (apb_req.paddr == `DMAT_STAT_OFS) begin
                next_s.rr = s.rr; // status is read only
            end else if ((apb_req.paddr & 8'hF0) == `DMAT_CCTL_BASE) begin
                next_s.ch[idx].sel =
                    apb_req.pwdata[`DMAT_CCTL_SEL_HI:`DMAT_CCTL_SEL_LO];
                next_s.ch[idx].en = apb_req.pwdata[`DMAT_CCTL_EN];
                next_s.ch[idx].swreq = apb_req.pwdata[`DMAT_CCTL_SWREQ];
                next_s.ch[idx].done = apb_req.pwdata[`DMAT_CCTL_DONE];
                next_s.ch[idx].level = apb_req.pwdata[`DMAT_CCTL_LEVEL];
                next_s.ch[idx].mode =
                    apb_req.pwdata[`DMAT_CCTL_MODE_HI:`DMAT_CCTL_MODE_LO];
            end else begin
                next_s.ch[idx].size = apb_req.pwdata[15:0];
            end
        end

        // ==================================================
        // edge capture of triggers, consumed when a transfer starts
        // a capture on a disabled channel waits until it is served
        next_s.trig_q = trig;
        next_s.pend = s.pend | (trig & ~s.trig_q);

        // ==================================================
        // engine
        // a unit is rd, wr, wt; sync comes only before the first
        case (s.fsm)
            DMAT_IDLE: begin
                // choose only here, so nothing running is preempted
                if (gnt_valid) begin
                    next_s.cur = gnt_idx;
                    next_s.pend[gnt_idx] = 1'b0;
                    next_s.cpu_halt = 1'b1;
                    if (s.ch[gnt_idx].sel == `DMAT_SEL_SOFT) begin
                        next_s.ch[gnt_idx].swreq = 1'b0;
                    end
                    // serial flags are only cleared when the module exists
                    if (s.ch[gnt_idx].sel == `DMAT_SEL_SRX) begin
                        next_s.rx_clr = trig_in.serial_b_fitted;
                    end
                    if (s.ch[gnt_idx].sel == `DMAT_SEL_STX) begin
                        next_s.tx_clr = trig_in.serial_b_fitted;
                    end
                    if (!mclk_running) begin
                        // clock is off: ask for the oscillator clock
                        next_s.mclk_req = 1'b1;
                        next_s.cnt = 10'(`DMAT_OSC_START_CYC);
                        next_s.fsm = DMAT_WAKE;
                    end else begin
                        // low power costs one more sync cycle
                        next_s.cnt = cpu_off ? `DMAT_SYNC_LOWPWR
                                             : `DMAT_SYNC_ACTIVE;
                        next_s.fsm = DMAT_SYNC;
                    end
                end
            end
            DMAT_WAKE: begin
                // the oscillator start allowance bounds the wait
                // a dead oscillator cannot hang the engine
                if (mclk_running || s.cnt == 10'h000) begin
                    next_s.cnt = `DMAT_SYNC_LOWPWR;
                    next_s.fsm = DMAT_SYNC;
                end else begin
                    next_s.cnt = s.cnt - 10'h001;
                end
            end
            DMAT_SYNC: begin
                if (s.cnt == 10'h000) begin
                    next_s.fsm = DMAT_RD;
                end else begin
                    next_s.cnt = s.cnt - 10'h001;
                end
            end
            DMAT_RD: begin
                // a dropped level trigger holds the engine here
                // size is untouched while paused, so it resumes in place
                if (!(s.ch[c].level && !trig[c])) begin
                    next_s.xrd = 1'b1;
                    next_s.fsm = DMAT_WR;
                end
            end
            DMAT_WR: begin
                next_s.xwr = 1'b1;
                next_s.fsm = DMAT_WT;
            end
            DMAT_WT: begin
                // one wait cycle closes each unit
                next_s.ch[c].size = s.ch[c].size - 16'h0001;
                if (s.ch[c].size == 16'h0001) begin
                    next_s.ch[c].done = 1'b1;
                    next_s.ch[c].en = 1'b0;
                    fin = 1'b1;
                end else if (s.ch[c].mode == `DMAT_MODE_SINGLE) begin
                    fin = 1'b1;
                end else if (s.ch[c].mode == `DMAT_MODE_BURST
                        && !s.ch[c].en) begin
                    fin = 1'b1;
                end else begin
                    next_s.fsm = DMAT_RD;
                end
            end
            default: begin
                next_s.fsm = DMAT_IDLE;
            end
        endcase

        // ==================================================
        // nmi abort, only while a transfer runs
        // it cuts in at once, even in the middle of a unit
        if (s.fsm != DMAT_IDLE && s.nmi_en && nmi) begin
            fin = 1'b1;
        end

        // end of transfer: release cpu and clock, rotate if asked
        if (fin) begin
            next_s.fsm = DMAT_IDLE;
            next_s.cpu_halt = 1'b0;
            next_s.mclk_req = 1'b0;
            next_s.xrd = 1'b0;
            next_s.xwr = 1'b0;
            if (s.rr) begin
                next_s.top = (c == 2'h2) ? 2'h0 : 2'(c + 2'h1);
            end
        end
        if (!s.rr) begin
            next_s.top = `DMAT_RST_TOP;
        end
    end

    // ======================================================
    // state register
    // one register for all state keeps every update in one place
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ======================================================
    // outputs straight from the state
    // no logic after the flops, so no output can glitch
    assign apb_rsp = s.rsp;
    assign mclk_request = s.mclk_req;
    assign cpu_halt = s.cpu_halt;
    assign serial_b_rx_clear = s.rx_clr;
    assign serial_b_tx_clear = s.tx_clr;
    assign xfer_read = s.xrd;
    assign xfer_write = s.xwr;
    assign xfer_chan = s.cur;
    assign channel_done_flag = {s.ch[2].done, s.ch[1].done, s.ch[0].done};
endmodule

// ---- design/dmat_pkg.sv ----
package dmat_pkg;

    // ======================================================
    // engine states
    typedef enum logic [2:0] {
        DMAT_IDLE,
        DMAT_WAKE,
        DMAT_SYNC,
        DMAT_RD,
        DMAT_WR,
        DMAT_WT
    } dmat_fsm_t;

    // ======================================================
    // per channel configuration and counter
    typedef struct packed {
        logic [1:0] mode;
        logic level;
        logic done;
        logic swreq;
        logic en;
        logic [3:0] sel;
        logic [15:0] size;
    } dmat_chan_t;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } dmat_apb_req_t;

    // apb answer to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } dmat_apb_rsp_t;

    // trigger sources from the peripherals
    typedef struct packed {
        logic mpy_ready;
        logic serial_b_fitted;
        logic serial_b_rx_flag;
        logic serial_b_rx_irq_enable;
        logic serial_b_tx_flag;
        logic serial_b_tx_irq_enable;
        logic external_trigger_pin;
    } dmat_trig_in_t;

    // whole module state
    typedef struct packed {
        dmat_apb_rsp_t rsp;
        logic rr;
        logic nmi_en;
        dmat_chan_t [2:0] ch;
        logic [2:0] pend;
        logic [2:0] trig_q;
        dmat_fsm_t fsm;
        logic [1:0] cur;
        logic [1:0] top;
        logic [9:0] cnt;
        logic mclk_req;
        logic cpu_halt;
        logic rx_clr;
        logic tx_clr;
        logic xrd;
        logic xwr;
    } dmat_state_t;

endpackage

// ---- verification/dmat_core_tb.sv ----
`timescale 1ns/100ps
module dmat_core_tb
    import dmat_pkg::*;
;
    logic pclk = 0, presetn = 0, nmi = 0, cpu_off = 0;
    logic mpy = 0, fit = 1, rx_ie = 0, tx_ie = 0, ext = 0;
    logic set_rx = 0, set_tx = 0, clk_off = 0, er, saw;
    logic rx_f, tx_f, run, mreq, halt, rx_clr, tx_clr, rd, wr;
    logic [1:0] chan;
    logic [2:0] done;
    logic [1:0] got [8];
    logic [31:0] q;
    dmat_apb_req_t req = '0;
    dmat_apb_rsp_t rsp;
    dmat_trig_in_t trig;
    int bad_count = 0, cmp_count = 0, n, cyc = 0;
    logic [3:0] srcs [4] = '{4'hB, 4'hC, 4'hD, 4'hF};

    assign trig = '{mpy, fit, rx_f, rx_ie, tx_f, tx_ie, ext};
    dmat_core i_dut (.pclk(pclk), .presetn(presetn),
        .apb_req(req), .apb_rsp(rsp), .trig_in(trig), .nmi(nmi),
        .mclk_running(run), .cpu_off(cpu_off), .mclk_request(mreq),
        .cpu_halt(halt), .serial_b_rx_clear(rx_clr),
        .serial_b_tx_clear(tx_clr), .xfer_read(rd), .xfer_write(wr),
        .xfer_chan(chan), .channel_done_flag(done));
    dmat_periph_model i_peri (.pclk(pclk), .presetn(presetn),
        .set_rx(set_rx), .set_tx(set_tx), .rx_clear(rx_clr),
        .tx_clear(tx_clr), .clk_off(clk_off), .mclk_request(mreq),
        .rx_flag(rx_f), .tx_flag(tx_f), .mclk_running(run));

    // ======================================================
    // clock and hang guard
    initial begin
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
    end

    // ======================================================
    // shared helpers
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // setup then access; held until pready seen at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (rsp.pready !== 1'b1) @(posedge pclk);
        q = rsp.prdata;
        er = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task cfg(input int c, input logic [3:0] s, input logic [1:0] m,
        input logic [15:0] sz, input logic sw);
        apb(1, 8'(8'h20 + 4 * c), {16'h0, sz});
        apb(1, 8'(8'h10 + 4 * c), {22'h0, m, 2'b00, sw, 1'b1, s});
    endtask
    // record the channel of the first 8 units within a window
    task collect(input int cy);
        n = 0;
        saw = 0;
        repeat (cy) begin
            @(posedge pclk);
            if (rd === 1'b1 && n < 8) begin
                got[n] = chan;
                n++;
            end
            if (mreq === 1'b1) saw = 1;
        end
    endtask
    task wait_wr;
        do begin
            @(posedge pclk);
        end while (wr !== 1'b1);
    endtask
    task prio3;
        for (int c = 0; c < 3; c++) cfg(c, 4'hF, 2'h0, 16'h1, 1'b0);
        @(posedge pclk) ext <= 1'b1;
        collect(60);
        ext <= 1'b0;
    endtask

    // ======================================================
    // scenarios
    task t_regs;
        apb(0, 8'h00, 0);
        chk("gctl reset", q, 0);
        apb(0, 8'h14, 0);
        chk("ctl1 reset", q, 0);
        apb(1, 8'h40, 32'h1);
        chk("unmapped err", er, 1);
    endtask
    task t_single;
        cfg(0, 4'h0, 2'h0, 16'h1, 1'b1);
        collect(20);
        chk("units", n, 1);
        chk("done0", done[0], 1);
        apb(0, 8'h10, 0);
        chk("swreq cleared", q[5], 0);
    endtask
    task t_sources;
        foreach (srcs[i]) begin
            cfg(1, srcs[i], 2'h0, 16'h1, 1'b0);
            @(posedge pclk);
            mpy <= srcs[i] == 4'hB;
            ext <= srcs[i] == 4'hF;
            set_rx <= srcs[i] == 4'hC;
            set_tx <= srcs[i] == 4'hD;
            @(posedge pclk);
            set_rx <= 1'b0;
            set_tx <= 1'b0;
            collect(20);
            mpy <= 1'b0;
            ext <= 1'b0;
            chk("source units", n, 1);
            chk("flags cleared", {rx_f, tx_f}, 0);
        end
        fit <= 1'b0;
        cfg(1, 4'hC, 2'h0, 16'h1, 1'b0);
        @(posedge pclk) set_rx <= 1'b1;
        @(posedge pclk) set_rx <= 1'b0;
        collect(20);
        chk("unfitted", n, 0);
        apb(1, 8'h14, 0);
        fit <= 1'b1;
        tx_ie <= 1'b1;
        cfg(1, 4'hD, 2'h0, 16'h1, 1'b0);
        @(posedge pclk) set_tx <= 1'b1;
        @(posedge pclk) set_tx <= 1'b0;
        collect(20);
        chk("tx masked", n, 0);
        apb(1, 8'h14, 0);
    endtask
    task t_chain;
        cpu_off <= 1'b1;
        apb(1, 8'h10, 0);
        cfg(1, 4'hE, 2'h0, 16'h1, 1'b0);
        cfg(0, 4'h0, 2'h0, 16'h1, 1'b1);
        collect(40);
        chk("chain order", {n[3:0], got[0], got[1]}, 8'h21);
        chk("done0 kept", done[0], 1);
        cpu_off <= 1'b0;
    endtask
    task t_prio;
        prio3();
        chk("fixed", {got[0], got[1], got[2]}, 6'b00_01_10);
        apb(1, 8'h00, 1);
        cfg(1, 4'h0, 2'h0, 16'h1, 1'b1);
        collect(20);
        prio3();
        chk("rotated", {got[0], got[1], got[2]}, 6'b10_00_01);
        apb(1, 8'h00, 0);
        prio3();
        chk("restored", {got[0], got[1], got[2]}, 6'b00_01_10);
    endtask
    task t_preempt;
        cfg(2, 4'h0, 2'h1, 16'h3, 1'b1);
        fork
            collect(60);
            cfg(0, 4'h0, 2'h0, 16'h1, 1'b1);
        join
        chk("no preempt", {got[0], got[1], got[2], got[3]}, 8'hA8);
    endtask
    task t_abort;
        apb(1, 8'h00, 2);
        cfg(0, 4'h0, 2'h1, 16'h4, 1'b1);
        wait_wr();
        nmi <= 1'b1;
        @(posedge pclk) nmi <= 1'b0;
        collect(30);
        chk("nmi stop", n < 2, 1);
        chk("nmi no done", done[0], 0);
        apb(1, 8'h00, 0);
        cfg(0, 4'h0, 2'h2, 16'h8, 1'b1);
        wait_wr();
        apb(1, 8'h10, 32'h200);
        collect(30);
        chk("burst stop", n < 2, 1);
        chk("burst no done", done[0], 0);
    endtask
    task t_clkoff;
        clk_off <= 1'b1;
        cpu_off <= 1'b1;
        cfg(0, 4'h0, 2'h0, 16'h1, 1'b1);
        collect(60);
        chk("woken unit", n, 1);
        chk("clock asked", saw, 1);
        chk("clock freed", mreq, 0);
        chk("cpu freed", halt, 0);
        clk_off <= 1'b0;
        cpu_off <= 1'b0;
    endtask

    // block on a level trigger: low pauses, high resumes
    task t_level;
        apb(1, 8'h20, 32'h3);
        apb(1, 8'h10, 32'h19F);
        ext <= 1'b1;
        wait_wr();
        ext <= 1'b0;
        collect(20);
        chk("level paused", n, 0);
        ext <= 1'b1;
        collect(30);
        chk("level resumed", n, 2);
        chk("level done", done[0], 1);
        ext <= 1'b0;
    endtask

    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ======================================================
    // main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_single();
        t_sources();
        t_chain();
        t_prio();
        t_preempt();
        t_abort();
        t_clkoff();
        t_level();
        print_verdict();
    end
endmodule

// ---- verification/dmat_periph_model.sv ----
`timescale 1ns/100ps
// ==========================================================
// serial flags and the sleeping clock seen by the engine
module dmat_periph_model #(
    parameter int WAKE = 5
) (
    input wire logic pclk, // master clock
    input wire logic presetn, // async reset
    input wire logic set_rx, // new rx data
    input wire logic set_tx, // tx ready
    input wire logic rx_clear, // rx clear pulse
    input wire logic tx_clear, // tx clear pulse
    input wire logic clk_off, // clock asleep
    input wire logic mclk_request, // wake request
    output logic rx_flag, // rx flag
    output logic tx_flag, // tx flag
    output logic mclk_running // clock on
);
    logic [3:0] wk;

    // flags drop only on the engine's clear; oscillator needs WAKE
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_flag <= 1'b0;
            tx_flag <= 1'b0;
            wk <= 4'h0;
        end else begin
            if (set_rx) rx_flag <= 1'b1;
            else if (rx_clear) rx_flag <= 1'b0;
            if (set_tx) tx_flag <= 1'b1;
            else if (tx_clear) tx_flag <= 1'b0;
            if (!mclk_request) wk <= 4'h0;
            else if (wk != 4'(WAKE)) wk <= wk + 4'h1;
        end
    end
    assign mclk_running = !clk_off || wk == 4'(WAKE);
endmodule

// ---- verification/dmat_properties.sv ----
`timescale 1ns/100ps
// ==========================================================
// port checks for the transfer engine
module dmat_properties
    import dmat_pkg::*;
(
    input wire logic pclk, // master clock
    input wire logic presetn, // async reset
    input wire dmat_apb_req_t apb_req, // apb request
    input wire dmat_apb_rsp_t apb_rsp, // apb answer
    input wire dmat_trig_in_t trig_in, // triggers
    input wire logic nmi, // nmi input
    input wire logic mclk_running, // clock on
    input wire logic cpu_off, // cpu asleep
    input wire logic mclk_request, // clock held up
    input wire logic cpu_halt, // cpu held
    input wire logic serial_b_rx_clear, // rx clear
    input wire logic serial_b_tx_clear, // tx clear
    input wire logic xfer_read, // read cycle
    input wire logic xfer_write, // write cycle
    input wire logic [1:0] xfer_chan, // channel
    input wire logic [2:0] channel_done_flag // done flags
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // one unit: read, write, then one idle wait cycle
    sequence s_unit;
        xfer_read ##1 xfer_write ##1 (!xfer_read && !xfer_write);
    endsequence

    a_unit_shape: assert property (xfer_read |-> s_unit)
        else $error("unit is not read, write, wait");
    a_write_paired: assert property (
        xfer_write |-> $past(xfer_read))
        else $error("write without a read before it");
    a_halt_covers: assert property (
        (xfer_read || xfer_write) |-> cpu_halt)
        else $error("data moved while cpu not held");
    a_sync_first: assert property (
        $rose(cpu_halt) |-> !xfer_read [*2])
        else $error("no sync cycle before data");
    a_active_bound: assert property (
        $rose(cpu_halt) && mclk_running && !cpu_off |-> ##2 xfer_read)
        else $error("active single transfer too slow");
    a_lowpwr_bound: assert property (
        $rose(cpu_halt) && mclk_running && cpu_off |-> ##3 xfer_read)
        else $error("low power single transfer too slow");
    a_clock_release: assert property (
        $fell(cpu_halt) |-> ##[0:1] !mclk_request)
        else $error("clock request kept after transfer");
    a_rx_clear_ok: assert property (
        serial_b_rx_clear |-> trig_in.serial_b_fitted
            && !trig_in.serial_b_rx_irq_enable)
        else $error("rx flag cleared while not eligible");
    a_tx_clear_ok: assert property (
        serial_b_tx_clear |-> trig_in.serial_b_fitted
            && !trig_in.serial_b_tx_irq_enable)
        else $error("tx flag cleared while not eligible");
    a_done_at_end: assert property (
        |(channel_done_flag & ~$past(channel_done_flag))
            |-> $past(xfer_write))
        else $error("done flag set away from a unit end");
    a_chan_steady: assert property (
        xfer_read |=> $stable(xfer_chan) [*2])
        else $error("channel changed inside a unit");
endmodule

bind dmat_core dmat_properties i_props (.pclk(pclk),
    .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .trig_in(trig_in), .nmi(nmi), .mclk_running(mclk_running),
    .cpu_off(cpu_off), .mclk_request(mclk_request),
    .cpu_halt(cpu_halt), .serial_b_rx_clear(serial_b_rx_clear),
    .serial_b_tx_clear(serial_b_tx_clear), .xfer_read(xfer_read),
    .xfer_write(xfer_write), .xfer_chan(xfer_chan),
    .channel_done_flag(channel_done_flag));
